// *** src/pulse_switch_pkg.sv ***
// Constants and state types shared by the pulse-counting switch controller.
package pulse_switch_pkg;
  localparam int  CLK_MHZ            = 200;
  localparam int  LATCH_TIMEOUT_US   = 500;
  localparam int  OFF_TIMEOUT_US     = 500;
  localparam int  TURN_ON_MAX_NS     = 2700;
  localparam int  LATCH_TIMEOUT_CYC  = LATCH_TIMEOUT_US * CLK_MHZ;
  localparam int  OFF_TIMEOUT_CYC    = OFF_TIMEOUT_US * CLK_MHZ;
  localparam int  TURN_ON_MAX_CYC    = (TURN_ON_MAX_NS * CLK_MHZ) / 1000;
  localparam int  TIMER_W            = 20;
  localparam int  CHANNELS_DEFAULT   = 3;

  typedef enum logic [1:0] {
    ST_SHUTDOWN,
    ST_COUNT_HIGH,
    ST_COUNT_LOW,
    ST_LATCHED
  } link_state_type;
endpackage

// *** src/level_timer.sv ***
// Counter that flags when a level has held for a programmable number of cycles.
`timescale 1ns/1ps
module level_timer
  import pulse_switch_pkg::*;
#(
  parameter int WIDTH = TIMER_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Control
  input  wire logic             restart,
  input  wire logic [WIDTH-1:0] limit,
  // Status
  output logic                  expired
);
  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             done;
  } timer_state_type;

  timer_state_type s_q;
  timer_state_type s_d;

  always_comb begin
    s_d = s_q;
    if (restart) begin
      s_d.count = '0;
      s_d.done  = 1'b0;
    end else if (!s_q.done) begin
      s_d.count = s_q.count + 1'b1;
      if (s_q.count + 1'b1 >= limit) begin
        s_d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign expired = s_q.done;
endmodule

// *** src/pulse_count_switch_control.sv ***
// Single-wire pulse-counting controller for a bank of low-side load switches.
//
// How it works
// - Each rising edge of the control line after the first one after shutdown adds one to the pulse counter.
// - With three channels the counter has 8 states and wraps after 8 pulses.
// - With six channels the counter decodes into 64 states, one per output combination.
// - A switch is on exactly where the matching bit of the pulse count minus one is zero.
// - The first rising edge after shutdown enables the device and selects all switches on.
// - The counted state is applied once the line has stayed high for the latch timeout.
// - Pulses are counted correctly at toggle rates up to 1 MHz.
// - A new switch turns on only after latch timeout expiry and within 2.7 us of it.
// - A switch that is on pulls its load pin to ground and one that is off leaves it open.
// - After the line has been low for the off timeout the device shuts down.
// - While shut down every switch is held open regardless of the last latched pattern.
`timescale 1ns/1ps
module pulse_count_switch_control
  import pulse_switch_pkg::*;
#(
  parameter int CHANNELS  = CHANNELS_DEFAULT,
  parameter int LATCH_CYC = LATCH_TIMEOUT_CYC,
  parameter int OFF_CYC   = OFF_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // Control line from the host
  input  wire logic                ctrl_line,
  // Load switches, output enable high means the drain is pulled to ground
  output logic [CHANNELS-1:0]      load_drain_out,
  output logic [CHANNELS-1:0]      load_drain_oe,
  // Status
  output logic                     enabled,
  output logic [CHANNELS-1:0]      switch_on
);
  typedef struct packed {
    logic                sync1;
    logic                sync2;
    logic                prev;
    link_state_type      state;
    logic [CHANNELS-1:0] count;
    logic [CHANNELS-1:0] latched;
    logic                en;
  } ctrl_state_type;

  ctrl_state_type s_q;
  ctrl_state_type s_d;
  logic           rise;
  logic           fall;
  logic           high_expired;
  logic           low_expired;
  logic           high_restart;
  logic           low_restart;

  // Switch pattern for a count that already holds n-1 is simply its inverse.
  function automatic logic [CHANNELS-1:0] decode_pattern(input logic [CHANNELS-1:0] cnt_m1);
    decode_pattern = ~cnt_m1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // The synchroniser costs two cycles of latency, far below the 50 ns minimum high time.
  assign rise = s_q.sync2 && !s_q.prev;
  assign fall = !s_q.sync2 && s_q.prev;
  assign high_restart = !s_q.sync2 || rise;
  assign low_restart  = s_q.sync2 || fall;

  level_timer #(.WIDTH(TIMER_W)) u_high_timer (
    .clk     (clk),
    .srst    (srst),
    .restart (high_restart),
    .limit   (TIMER_W'(LATCH_CYC)),
    .expired (high_expired)
  );

  level_timer #(.WIDTH(TIMER_W)) u_low_timer (
    .clk     (clk),
    .srst    (srst),
    .restart (low_restart),
    .limit   (TIMER_W'(OFF_CYC)),
    .expired (low_expired)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d       = s_q;
    s_d.sync1 = ctrl_line;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
    case (s_q.state)
      ST_SHUTDOWN: begin
        if (rise) begin
          s_d.en    = 1'b1;
          s_d.count = '0;
          s_d.state = ST_COUNT_HIGH;
        end
      end
      ST_COUNT_HIGH, ST_LATCHED: begin
        if (fall) begin
          s_d.state = ST_COUNT_LOW;
        end else if (high_expired && s_q.state == ST_COUNT_HIGH) begin
          s_d.latched = decode_pattern(s_q.count);
          s_d.state   = ST_LATCHED;
        end
      end
      ST_COUNT_LOW: begin
        if (rise) begin
          s_d.count = s_q.count + 1'b1;
          s_d.state = ST_COUNT_HIGH;
        end else if (low_expired) begin
          s_d.en      = 1'b0;
          s_d.latched = '0;
          s_d.state   = ST_SHUTDOWN;
        end
      end
      default: begin
        s_d.state = ST_SHUTDOWN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs keep the previous pattern through a new pulse train until it latches.
  // The pattern register is cleared on shutdown, so the switches hang straight off a flip-flop.
  assign switch_on      = s_q.latched;
  assign load_drain_out = '0;
  assign load_drain_oe  = switch_on;
  assign enabled        = s_q.en;

  ////////////////////////////////////////////////////////////////////////////
  // Turn-on bound in clock cycles; the latch itself lands one cycle after expiry.
  localparam int TURN_ON_LIMIT = TURN_ON_MAX_CYC;

  property p_latch_apply;
    @(posedge clk) disable iff (srst)
      (s_q.state == ST_COUNT_HIGH && high_expired && !fall) |=> (switch_on == ~$past(s_q.count));
  endproperty
  a_latch_apply: assert property (p_latch_apply) else $error("latched pattern wrong");

  property p_first_rise_all_on;
    @(posedge clk) disable iff (srst)
      (s_q.state == ST_SHUTDOWN && rise) |=> (s_q.count == '0 && s_q.en);
  endproperty
  a_first_rise_all_on: assert property (p_first_rise_all_on) else $error("first edge not all on");

  property p_count_step;
    @(posedge clk) disable iff (srst)
      (s_q.state == ST_COUNT_LOW && rise) |=> (s_q.count == $past(s_q.count) + 1'b1);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not advance");

  property p_wrap;
    @(posedge clk) disable iff (srst)
      (s_q.state == ST_COUNT_LOW && rise && s_q.count == '1) |=> (s_q.count == '0);
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap");

  property p_shutdown_open;
    @(posedge clk) disable iff (srst)
      !s_q.en |-> (load_drain_oe == '0);
  endproperty
  a_shutdown_open: assert property (p_shutdown_open) else $error("switch closed while disabled");

  property p_off_timeout;
    @(posedge clk) disable iff (srst)
      (s_q.state == ST_COUNT_LOW && low_expired && !rise) |=> (!s_q.en && s_q.state == ST_SHUTDOWN);
  endproperty
  a_off_timeout: assert property (p_off_timeout) else $error("no shutdown after off timeout");

  property p_no_early_change;
    @(posedge clk) disable iff (srst)
      (s_q.en && $past(s_q.en) && !$past(high_expired)) |-> $stable(switch_on);
  endproperty
  a_no_early_change: assert property (p_no_early_change) else $error("outputs changed before timeout");

  property p_drain_ground;
    @(posedge clk) disable iff (srst)
      (load_drain_oe == switch_on) && (load_drain_out == '0);
  endproperty
  a_drain_ground: assert property (p_drain_ground) else $error("drain drive wrong");

  property p_turn_on_bound;
    @(posedge clk) disable iff (srst)
      (s_q.state == ST_COUNT_HIGH && high_expired && !fall) |-> ##[1:TURN_ON_LIMIT] (switch_on == ~s_q.count);
  endproperty
  a_turn_on_bound: assert property (p_turn_on_bound) else $error("pattern late after latch timeout");

  // Only a rising edge may move the counter, so a long high or low phase leaves the count alone.
  property p_count_hold;
    @(posedge clk) disable iff (srst)
      !rise |=> $stable(s_q.count);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved without an edge");

  property p_enable_on_edge;
    @(posedge clk) disable iff (srst)
      (!s_q.en && !rise) |=> !s_q.en;
  endproperty
  a_enable_on_edge: assert property (p_enable_on_edge) else $error("enabled without a rising edge");

  property p_stay_on_high;
    @(posedge clk) disable iff (srst)
      (s_q.en && s_q.sync2) |=> s_q.en;
  endproperty
  a_stay_on_high: assert property (p_stay_on_high) else $error("shut down while line high");

  c_latch:    cover property (@(posedge clk) disable iff (srst) s_q.state == ST_LATCHED);
  c_wrap:     cover property (@(posedge clk) disable iff (srst) s_q.count == '1 ##1 s_q.count == '0);
  c_shutdown: cover property (@(posedge clk) disable iff (srst) $fell(s_q.en));
  // A second train on top of a latched pattern, which keeps counting instead of starting over.
  c_reseq:    cover property (@(posedge clk) disable iff (srst)
                s_q.state == ST_COUNT_LOW && rise && s_q.latched != '0);
endmodule

// *** sim/host_gpio.sv ***
// Host GPIO model that drives the control line with counted pulse trains.
`timescale 1ns/1ps
module host_gpio #(
  parameter int HI_CYC = 10,
  parameter int LO_CYC = 190
) (
  // Clock
  input  wire logic clk,
  // Control line
  output logic      ctrl_line
);
  // Ten high and 190 low cycles make a 1 us period, the fastest toggle rate the line allows.
  initial ctrl_line = 1'b0;
  // Sends n rising edges, then leaves the line high so the count latches.
  task automatic send(input int n);
    for (int i = 0; i < n; i++) begin
      if (i > 0) begin
        ctrl_line <= 1'b0;
        repeat (LO_CYC) @(posedge clk);
      end
      ctrl_line <= 1'b1;
      repeat (HI_CYC) @(posedge clk);
    end
  endtask
  // A long low asks the device to shut down.
  task automatic drop();
    ctrl_line <= 1'b0;
  endtask
endmodule

// *** sim/pulse_count_switch_control_test.sv ***
// Self-checking bench for the pulse-counting switch controller.
`timescale 1ns/1ps
module pulse_count_switch_control_test;
  import pulse_switch_pkg::*;
  localparam int CH  = 3;
  localparam int CW  = 6;
  localparam int LAT = 60;
  localparam int OFF = 300;
  localparam int GAP = 190;
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  wire           ctrl_line;
  logic [CH-1:0] drain_out;
  logic [CH-1:0] drain_oe;
  logic [CH-1:0] sw_on;
  logic          en;
  logic [CW-1:0] wide_out;
  logic [CW-1:0] wide_oe;
  logic [CW-1:0] wide_on;
  logic          wide_en;
  int            n_errors = 0;
  int            checked = 0;
  int            cycles = 0;
  always #2.5 clk = ~clk;
  pulse_count_switch_control #(.CHANNELS(CH), .LATCH_CYC(LAT), .OFF_CYC(OFF)) dut (
    .clk            (clk),
    .srst           (srst),
    .ctrl_line      (ctrl_line),
    .load_drain_out (drain_out),
    .load_drain_oe  (drain_oe),
    .enabled        (en),
    .switch_on      (sw_on)
  );
  host_gpio host (
    .clk       (clk),
    .ctrl_line (ctrl_line)
  );
  // A six-channel copy on the same line checks the wider decode and its wrap.
  pulse_count_switch_control #(.CHANNELS(CW), .LATCH_CYC(LAT), .OFF_CYC(OFF)) dut_wide (
    .clk            (clk),
    .srst           (srst),
    .ctrl_line      (ctrl_line),
    .load_drain_out (wide_out),
    .load_drain_oe  (wide_oe),
    .enabled        (wide_en),
    .switch_on      (wide_on)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [CH-1:0] got, input logic [CH-1:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic check_wide(input logic [CW-1:0] got, input logic [CW-1:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // A stuck wait ends the run rather than hanging it.
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Each train starts from shutdown, so count n maps straight to a pattern.
  task automatic count_and_latch(input int n);
    logic [CH-1:0] exp;
    logic [CW-1:0] exp_wide;
    exp = CH'(~(n - 1));
    exp_wide = CW'(~(n - 1));
    host.send(n);
    repeat (LAT - 20) @(posedge clk);
    #1;
    check(drain_oe, '0, "early turn on");
    repeat (30) @(posedge clk);
    #1;
    check(sw_on, exp, "pattern");
    check(drain_oe, exp, "drain enable");
    check(drain_out, '0, "drain level");
    check({CH{en}}, '1, "enabled");
    check_wide(wide_on, exp_wide, "wide pattern");
    check_wide(wide_out, '0, "wide drain level");
    check_wide({CW{wide_en}}, '1, "wide enabled");
    @(posedge clk);
    host.drop();
    repeat (OFF - 20) @(posedge clk);
    #1;
    check(drain_oe, exp, "held while low");
    repeat (40) @(posedge clk);
    #1;
    check({CH{en}}, '0, "shutdown");
    check(drain_oe, '0, "open while off");
    check_wide(wide_oe, '0, "wide open while off");
    @(posedge clk);
  endtask
  // Brings the line low and waits out the off timeout, then checks that both devices let go.
  task automatic shut_down();
    @(posedge clk);
    host.drop();
    repeat (OFF + 20) @(posedge clk);
    #1;
    check({CH{en}}, '0, "shut down");
    check(drain_oe, '0, "open after shutdown");
    check_wide(wide_oe, '0, "wide open after shutdown");
    @(posedge clk);
  endtask
  // A second train on top of a latched pattern keeps counting from the first train's count.
  task automatic resequence();
    host.send(3);
    repeat (LAT + 30) @(posedge clk);
    #1;
    check(drain_oe, 3'h5, "first train");
    check_wide(wide_oe, 6'h3D, "wide first train");
    @(posedge clk);
    host.drop();
    repeat (GAP) @(posedge clk);
    host.send(2);
    #1;
    check(drain_oe, 3'h5, "held through new train");
    repeat (LAT) @(posedge clk);
    #1;
    check(drain_oe, 3'h3, "second train");
    check_wide(wide_oe, 6'h3B, "wide second train");
    shut_down();
  endtask
  // A reset in mid-run drops a latched pattern at once; the line is low again when it lifts.
  task automatic reset_mid_run();
    host.send(2);
    repeat (LAT + 30) @(posedge clk);
    #1;
    check(drain_oe, 3'h6, "before reset");
    check_wide(wide_oe, 6'h3E, "wide before reset");
    @(posedge clk);
    srst <= 1'b1;
    host.drop();
    repeat (6) @(posedge clk);
    #1;
    check({CH{en}}, '0, "disabled in reset");
    check(drain_oe, '0, "open in reset");
    check_wide(wide_oe, '0, "wide open in reset");
    @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    host.send(1);
    repeat (LAT + 30) @(posedge clk);
    #1;
    check(drain_oe, '1, "all on after reset");
    check_wide(wide_oe, '1, "wide all on after reset");
    shut_down();
  endtask
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (int n = 1; n <= 9; n++) begin
      count_and_latch(n);
    end
    count_and_latch(65);
    resequence();
    reset_mid_run();
    report_and_stop();
  end
endmodule
